// ---- hdl/dcirq_flag_bank.sv ----
/*
 * Sticky per-channel completion flags.
 * Assumes set pulses and clear masks come from logic on core_clk.
 */
`timescale 1ns/1ps
module dcirq_flag_bank (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Events and clears
	input  wire logic [3:0]  set_pulse,
	input  wire logic [3:0]  clear_mask,
	// Flags
	output      logic [3:0]  flags
);

	dcirq_pkg::dcirq_bank_state_s state_reg;
	dcirq_pkg::dcirq_bank_state_s state_next;

	// A set in the same cycle as a clear wins, so no completion is lost
	always_comb begin
		state_next       = state_reg;
		state_next.flags = (state_reg.flags & ~clear_mask) | set_pulse;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_reg.flags <= dcirq_pkg::RST_FLAGS;
		end else begin
			state_reg <= state_next;
		end
	end

	assign flags = state_reg.flags;

	property p_set_wins;
		@(posedge core_clk) disable iff (!resetn)
		(set_pulse != 4'h0) |=> ((flags & $past(set_pulse)) == $past(set_pulse));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag event lost");

	property p_flag_holds;
		@(posedge core_clk) disable iff (!resetn)
		(clear_mask == 4'h0) |=> ((flags & $past(flags)) == $past(flags));
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("flag dropped without clear");

endmodule : dcirq_flag_bank

// ---- hdl/dcirq_pkg.sv ----
/*
 * Shared constants and carriers for the transmit completion interrupt block.
 * Assumes a single core_clk domain and a plain register port with a
 * one-cycle read latency.
 */
package dcirq_pkg;

	// Widths
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned CHAN_N = 4;

	// Register byte offsets
	localparam logic [7:0] OFS_VECTOR_CAPTURE = 8'h00;
	localparam logic [7:0] OFS_MASKED_STATUS  = 8'h04;
	localparam logic [7:0] OFS_RAW_STATUS     = 8'h08;
	localparam logic [7:0] OFS_ENABLE_SET     = 8'h0C;
	localparam logic [7:0] OFS_ENABLE_CLEAR   = 8'h10;
	localparam logic [7:0] OFS_RX_DMA_CONTROL = 8'h14;

	// Field positions
	localparam int unsigned FLD_COMP_LSB   = 0;
	localparam int unsigned FLD_COMP_MSB   = 3;
	localparam int unsigned FLD_RX_ENABLE  = 0;

	// Values after reset
	localparam logic [31:0] RST_VECTOR     = 32'h0000_0000;
	localparam logic [3:0]  RST_FLAGS      = 4'h0;
	localparam logic [3:0]  RST_ENABLES    = 4'h0;
	localparam logic        RST_RX_ENABLE  = 1'b0;
	localparam logic [31:0] RST_RDATA      = 32'h0000_0000;
	localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;

	// Cycles from read strobe to read data
	localparam int unsigned READ_LATENCY   = 1;

	// Register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [7:0]        addr;
		logic [31:0]       wdata;
	} dcirq_bus_req_s;

	// Flag bank state
	typedef struct packed {
		logic [3:0]        flags;
	} dcirq_bank_state_s;

	// Main block state
	typedef struct packed {
		logic [31:0]       vector;
		logic [3:0]        enables;
		logic              rx_enable;
		logic [31:0]       rdata;
	} dcirq_state_s;

endpackage : dcirq_pkg

// ---- hdl/dcirq_regs.sv ----
/*
 * Transmit completion interrupt status and enables, vector capture and the
 * receive DMA global enable, reached over a plain register port.
 * Assumes completion pulses and the vector input come from logic on core_clk,
 * and the master never raises both strobes at once.
 */
// The plain strobed port and the register offsets were left to the implementer.
// Notes on behaviour
// - Read-only 32-bit vector register registers the vector input; zero after reset.
// - Four raw completion flags, set per channel on transmit completion; zero at reset.
// - Masked indicators read as raw flags ANDed with channel enables.
// - Four active-high completion enables, one per channel, reset to zero.
// - Writing one to the clear alias clears that enable; zeros leave it.
// - Writing one to the set alias sets that enable; zeros leave it.
// - Receive DMA global enable: one enables, zero disables, resets disabled.
`timescale 1ns/1ps
module dcirq_regs (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      resetn,
	// Register port
	input  wire dcirq_pkg::dcirq_bus_req_s bus_req,
	output      logic [31:0]               bus_rdata,
	// Engine side
	input  wire logic [31:0]               irq_vector_in,
	input  wire logic [3:0]                tx_done_pulse,
	// Controls and interrupt
	output      logic                      rx_dma_global_enable,
	output      logic [3:0]                tx_completion_enable,
	output      logic [3:0]                tx_raw_completion,
	output      logic                      tx_completion_irq
);

	dcirq_pkg::dcirq_state_s state_reg;
	dcirq_pkg::dcirq_state_s state_next;

	logic [3:0]  raw_flags;
	logic [3:0]  masked_flags;
	logic [3:0]  raw_clear;
	logic        hit_vector;
	logic        hit_masked;
	logic        hit_raw;
	logic        hit_set;
	logic        hit_clear;
	logic        hit_rx;

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		addr_hit = (addr == ofs);
	endfunction : addr_hit

	function automatic logic [31:0] comp_word(input logic [3:0] bits);
		comp_word = {28'h000_0000, bits};
	endfunction : comp_word

	assign hit_vector = addr_hit(bus_req.addr, dcirq_pkg::OFS_VECTOR_CAPTURE);
	assign hit_masked = addr_hit(bus_req.addr, dcirq_pkg::OFS_MASKED_STATUS);
	assign hit_raw    = addr_hit(bus_req.addr, dcirq_pkg::OFS_RAW_STATUS);
	assign hit_set    = addr_hit(bus_req.addr, dcirq_pkg::OFS_ENABLE_SET);
	assign hit_clear  = addr_hit(bus_req.addr, dcirq_pkg::OFS_ENABLE_CLEAR);
	assign hit_rx     = addr_hit(bus_req.addr, dcirq_pkg::OFS_RX_DMA_CONTROL);

	// Reading the raw status hands the flags to software and clears them
	assign raw_clear = (bus_req.rd && hit_raw) ? raw_flags : 4'h0;

	dcirq_flag_bank u_flag_bank (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.set_pulse  (tx_done_pulse),
		.clear_mask (raw_clear),
		.flags      (raw_flags)
	);

	assign masked_flags = raw_flags & state_reg.enables;

	always_comb begin
		state_next        = state_reg;
		state_next.vector = irq_vector_in;
		if (bus_req.wr && hit_set) begin
			state_next.enables = state_reg.enables | bus_req.wdata[3:0];
		end
		if (bus_req.wr && hit_clear) begin
			state_next.enables = state_reg.enables & ~bus_req.wdata[3:0];
		end
		if (bus_req.wr && hit_rx) begin
			state_next.rx_enable = bus_req.wdata[dcirq_pkg::FLD_RX_ENABLE];
		end
		// Read data stand for one cycle only; the master samples them once
		state_next.rdata = dcirq_pkg::RST_RDATA;
		if (bus_req.rd) begin
			if (hit_vector) begin
				state_next.rdata = state_reg.vector;
			end else if (hit_masked) begin
				state_next.rdata = comp_word(masked_flags);
			end else if (hit_raw) begin
				state_next.rdata = comp_word(raw_flags);
			end else if (hit_set || hit_clear) begin
				state_next.rdata = comp_word(state_reg.enables);
			end else if (hit_rx) begin
				state_next.rdata = {31'h0000_0000, state_reg.rx_enable};
			end else begin
				state_next.rdata = dcirq_pkg::READ_UNMAPPED;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_reg.vector    <= dcirq_pkg::RST_VECTOR;
			state_reg.enables   <= dcirq_pkg::RST_ENABLES;
			state_reg.rx_enable <= dcirq_pkg::RST_RX_ENABLE;
			state_reg.rdata     <= dcirq_pkg::RST_RDATA;
		end else begin
			state_reg <= state_next;
		end
	end

	assign bus_rdata            = state_reg.rdata;
	assign rx_dma_global_enable = state_reg.rx_enable;
	assign tx_completion_enable = state_reg.enables;
	assign tx_raw_completion    = raw_flags;
	// Level output built from flops only, so it carries no glitch from the bus
	assign tx_completion_irq    = |masked_flags;

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	logic past_valid_reg;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			past_valid_reg <= 1'b0;
		end else begin
			past_valid_reg <= 1'b1;
		end
	end

	sequence s_read_of(logic [7:0] ofs);
		bus_req.rd && (bus_req.addr == ofs);
	endsequence

	property p_vector_read;
		(past_valid_reg and s_read_of(dcirq_pkg::OFS_VECTOR_CAPTURE))
		|=> bus_rdata == $past(irq_vector_in, 2);
	endproperty
	a_vector_read: assert property (p_vector_read)
		else $error("vector read does not show registered input");

	property p_raw_read;
		s_read_of(dcirq_pkg::OFS_RAW_STATUS)
		|=> bus_rdata == comp_word($past(raw_flags));
	endproperty
	a_raw_read: assert property (p_raw_read)
		else $error("raw status read mismatch");

	property p_raw_clear_by_read;
		(s_read_of(dcirq_pkg::OFS_RAW_STATUS) and (tx_done_pulse == 4'h0))
		|=> raw_flags == 4'h0;
	endproperty
	a_raw_clear_by_read: assert property (p_raw_clear_by_read)
		else $error("raw status not cleared by read");

	property p_masked_read;
		s_read_of(dcirq_pkg::OFS_MASKED_STATUS)
		|=> bus_rdata == comp_word($past(raw_flags) & $past(tx_completion_enable));
	endproperty
	a_masked_read: assert property (p_masked_read)
		else $error("masked status is not raw AND enable");

	property p_enable_stable;
		!(bus_req.wr && (hit_set || hit_clear))
		|=> $stable(tx_completion_enable);
	endproperty
	a_enable_stable: assert property (p_enable_stable)
		else $error("enable changed without a set or clear write");

	property p_enable_clear;
		bus_req.wr && (bus_req.addr == dcirq_pkg::OFS_ENABLE_CLEAR)
		|=> tx_completion_enable == ($past(tx_completion_enable) & ~$past(bus_req.wdata[3:0]));
	endproperty
	a_enable_clear: assert property (p_enable_clear)
		else $error("enable clear alias misbehaves");

	property p_enable_set;
		bus_req.wr && (bus_req.addr == dcirq_pkg::OFS_ENABLE_SET)
		|=> tx_completion_enable == ($past(tx_completion_enable) | $past(bus_req.wdata[3:0]));
	endproperty
	a_enable_set: assert property (p_enable_set)
		else $error("enable set alias misbehaves");

	property p_rx_enable;
		bus_req.wr && (bus_req.addr == dcirq_pkg::OFS_RX_DMA_CONTROL)
		|=> rx_dma_global_enable == $past(bus_req.wdata[0]);
	endproperty
	a_rx_enable: assert property (p_rx_enable)
		else $error("receive DMA enable not written");

	property p_rx_reset_off;
		!past_valid_reg |-> !rx_dma_global_enable;
	endproperty
	a_rx_reset_off: assert property (p_rx_reset_off)
		else $error("receive DMA enabled after reset");

	property p_irq_after_event;
		// A clearing read in the event cycle cannot hide it, since set wins
		((tx_done_pulse & tx_completion_enable) != 4'h0) && !(bus_req.wr && hit_clear)
		|=> tx_completion_irq;
	endproperty
	a_irq_after_event: assert property (p_irq_after_event)
		else $error("enabled completion raised no interrupt");

	property p_irq_drop;
		tx_completion_irq && !(bus_req.rd && hit_raw) && !(bus_req.wr && hit_clear)
		|=> tx_completion_irq;
	endproperty
	a_irq_drop: assert property (p_irq_drop)
		else $error("interrupt dropped without a clearing access");

	property p_irq_masked;
		(tx_completion_enable == 4'h0) |-> !tx_completion_irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("interrupt raised with all channels disabled");

	property p_unmapped_read;
		bus_req.rd && !(hit_vector || hit_masked || hit_raw || hit_set || hit_clear || hit_rx)
		|=> bus_rdata == dcirq_pkg::READ_UNMAPPED;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read not zero");

	property p_rdata_one_cycle;
		!bus_req.rd |=> bus_rdata == dcirq_pkg::RST_RDATA;
	endproperty
	a_rdata_one_cycle: assert property (p_rdata_one_cycle)
		else $error("read data outside the answer cycle");

	// Main scenarios
	property p_cov_irq;
		tx_done_pulse != 4'h0 ##1 tx_completion_irq;
	endproperty
	c_cov_irq: cover property (p_cov_irq);

	property p_cov_read_clear;
		tx_completion_irq ##1 s_read_of(dcirq_pkg::OFS_RAW_STATUS) ##1 !tx_completion_irq;
	endproperty
	c_cov_read_clear: cover property (p_cov_read_clear);

	property p_cov_set_then_clear;
		bus_req.wr && hit_set ##1 bus_req.wr && hit_clear;
	endproperty
	c_cov_set_then_clear: cover property (p_cov_set_then_clear);

	property p_cov_event_on_read;
		s_read_of(dcirq_pkg::OFS_RAW_STATUS) and (tx_done_pulse != 4'h0);
	endproperty
	c_cov_event_on_read: cover property (p_cov_event_on_read);

endmodule : dcirq_regs

// ---- tb/dcirq_engine_model.sv ----
/*
 * Behavioural model of the transmit engine beside the completion block.
 * Assumes the bench asks for events and vector values on core_clk.
 */
`timescale 1ns/1ps
module dcirq_engine_model (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Requests from the bench
	input  wire logic [3:0]  fire,
	input  wire logic [31:0] vec_req,
	// Engine outputs
	output      logic [3:0]  tx_done_pulse,
	output      logic [31:0] irq_vector_in
);
	// One stage late, so a request lands a full cycle after the bench asks
	always_ff @(posedge core_clk) begin
		if (!resetn)
			tx_done_pulse <= 4'h0;
		else
			tx_done_pulse <= fire;
		irq_vector_in <= vec_req;
	end
endmodule : dcirq_engine_model

// ---- tb/tb.sv ----
/*
 * Self-checking bench for the completion interrupt registers.
 * Assumes one core_clk domain and the engine model as event source.
 */
`timescale 1ns/1ps
module tb;
	logic                      core_clk  = 1'b0;
	logic                      resetn    = 1'b0;
	dcirq_pkg::dcirq_bus_req_s bus_req   = '0;
	logic [3:0]                fire      = 4'h0;
	logic [31:0]               vec_req   = 32'h0000_0000;
	logic [31:0]               bus_rdata;
	logic [31:0]               irq_vector_in;
	logic [3:0]                tx_done_pulse;
	logic                      rx_en;
	logic                      irq;
	logic [3:0]                en_o;
	logic [3:0]                raw_o;
	logic                      rd_q      = 1'b0;
	logic [31:0]               exp_q[$];
	logic [3:0]                m_en      = 4'h0;
	logic [3:0]                m_flag    = 4'h0;
	logic                      m_rx      = 1'b0;
	logic [31:0]               d;
	int                        err_count = 0;
	int                        checked   = 0;

	always #2.5 core_clk = ~core_clk;

	dcirq_engine_model u_eng (.core_clk(core_clk), .resetn(resetn), .fire(fire),
		.vec_req(vec_req), .tx_done_pulse(tx_done_pulse), .irq_vector_in(irq_vector_in));
	dcirq_regs u_dut (.core_clk(core_clk), .resetn(resetn), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .irq_vector_in(irq_vector_in), .tx_done_pulse(tx_done_pulse),
		.rx_dma_global_enable(rx_en), .tx_completion_enable(en_o),
		.tx_raw_completion(raw_o), .tx_completion_irq(irq));

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	function automatic logic [31:0] exp_val(input logic [7:0] a);
		case (a)
			dcirq_pkg::OFS_VECTOR_CAPTURE: return vec_req;
			dcirq_pkg::OFS_MASKED_STATUS:  return {28'h000_0000, m_flag & m_en};
			dcirq_pkg::OFS_RAW_STATUS:     return {28'h000_0000, m_flag};
			dcirq_pkg::OFS_ENABLE_SET,
			dcirq_pkg::OFS_ENABLE_CLEAR:   return {28'h000_0000, m_en};
			dcirq_pkg::OFS_RX_DMA_CONTROL: return {31'h0000_0000, m_rx};
			default:                       return 32'h0000_0000;
		endcase
	endfunction : exp_val

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		if (a == dcirq_pkg::OFS_ENABLE_SET)
			m_en = m_en | v[3:0];
		if (a == dcirq_pkg::OFS_ENABLE_CLEAR)
			m_en = m_en & ~v[3:0];
		if (a == dcirq_pkg::OFS_RX_DMA_CONTROL)
			m_rx = v[0];
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		exp_q.push_back(exp_val(a));
		if (a == dcirq_pkg::OFS_RAW_STATUS)
			m_flag = 4'h0;
	endtask : rd

	task automatic idle;
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
		bus_req.rd <= 1'b0;
	endtask : idle

	task automatic ev(input logic [3:0] m);
		@(posedge core_clk);
		fire <= m;
		m_flag = m_flag | m;
		@(posedge core_clk);
		fire <= 4'h0;
		@(posedge core_clk);
	endtask : ev

	task automatic chk_outs;
		@(negedge core_clk);
		chk("irq", {31'h0000_0000, |(m_flag & m_en)}, {31'h0000_0000, irq});
		chk("enables", {28'h000_0000, m_en}, {28'h000_0000, en_o});
		chk("raw flags", {28'h000_0000, m_flag}, {28'h000_0000, raw_o});
		chk("rx enable", {31'h0000_0000, m_rx}, {31'h0000_0000, rx_en});
	endtask : chk_outs

	// Read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		rd_q <= bus_req.rd;
		if (rd_q && exp_q.size() == 0) begin
			err_count++;
			$display("unexpected read data: expected none seen %h", bus_rdata);
		end else if (rd_q)
			chk("read data", exp_q.pop_front(), bus_rdata);
		else if (resetn)
			chk("idle read data", 32'h0000_0000, bus_rdata);
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		$display("unexpected timeout: expected end seen hang");
		close_out();
	end

	initial begin
		void'($urandom(32'h7de0_73d7));
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i <= 24; i += 4)
			rd(8'(i));
		idle();
		chk_outs();
		repeat (6) begin
			d = $urandom;
			wr(dcirq_pkg::OFS_ENABLE_SET, d);
			rd(dcirq_pkg::OFS_ENABLE_SET);
			d = $urandom;
			wr(dcirq_pkg::OFS_ENABLE_CLEAR, d);
			rd(dcirq_pkg::OFS_ENABLE_CLEAR);
			idle();
			chk_outs();
		end
		// Write ones to the read-only vector and raw status, the enable clear alias and unmapped 0x18
		for (int i = 0; i <= 24; i += 8)
			wr(8'(i), 32'hFFFF_FFFF);
		for (int i = 0; i <= 24; i += 4)
			rd(8'(i));
		wr(dcirq_pkg::OFS_ENABLE_SET, 32'h0000_0005);
		wr(dcirq_pkg::OFS_ENABLE_CLEAR, 32'h0000_000A);
		idle();
		for (int ch = 0; ch < 4; ch++) begin
			ev(4'(1 << ch));
			chk_outs();
			rd(dcirq_pkg::OFS_MASKED_STATUS);
			rd(dcirq_pkg::OFS_RAW_STATUS);
			rd(dcirq_pkg::OFS_RAW_STATUS);
			idle();
			chk_outs();
		end
		ev(4'($urandom));
		rd(dcirq_pkg::OFS_MASKED_STATUS);
		idle();
		// Event in the same cycle as the clearing read must survive
		@(posedge core_clk);
		fire <= 4'h8;
		rd(dcirq_pkg::OFS_RAW_STATUS);
		fire <= 4'h0;
		m_flag = 4'h8;
		rd(dcirq_pkg::OFS_RAW_STATUS);
		repeat (3) begin
			idle();
			vec_req <= $urandom;
			repeat (3) @(posedge core_clk);
			rd(dcirq_pkg::OFS_VECTOR_CAPTURE);
		end
		wr(dcirq_pkg::OFS_RX_DMA_CONTROL, 32'hFFFF_FFFF);
		rd(dcirq_pkg::OFS_RX_DMA_CONTROL);
		idle();
		chk_outs();
		wr(dcirq_pkg::OFS_RX_DMA_CONTROL, 32'hFFFF_FFFE);
		rd(dcirq_pkg::OFS_RX_DMA_CONTROL);
		wr(dcirq_pkg::OFS_ENABLE_CLEAR, 32'h0000_000F);
		idle();
		ev(4'hF);
		chk_outs();
		wr(dcirq_pkg::OFS_ENABLE_SET, 32'h0000_0002);
		idle();
		chk_outs();
		rd(dcirq_pkg::OFS_RAW_STATUS);
		idle();
		chk_outs();
		repeat (3) @(posedge core_clk);
		if (exp_q.size() != 0) begin
			err_count++;
			$display("unexpected pending reads: expected 0 seen %0d", exp_q.size());
		end
		close_out();
	end
endmodule : tb
